// ===== hw/bcd_timer_pkg.sv
// Constants shared by the BCD timer and counter bank.
// Assumes one 100 MHz system clock; all values are packed BCD.

package bcd_timer_pkg;

  // Timebase, times in nanoseconds
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned FAST_TICK_NS     = 10_000_000;
  localparam int unsigned SLOW_TICK_NS     = 100_000_000;
  localparam int unsigned FAST_TICK_CYCLES = FAST_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned FAST_PER_SLOW    = SLOW_TICK_NS / FAST_TICK_NS;
  localparam int          PRESC_W          = 20;
  localparam int          DECADE_W         = 4;

  // BCD limits
  localparam logic [31:0] AT_MAX     = 32'h9999_9999;
  localparam logic [31:0] FT_MAX     = 32'h0999_9999;
  localparam logic [31:0] UD_MAX     = 32'h9999_9999;
  localparam logic [15:0] WORD_MAX   = 16'h9999;
  localparam logic [31:0] DWORD_ZERO = 32'h0000_0000;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;
  localparam logic [3:0]  BCD_NINE   = 4'h9;
  localparam logic [3:0]  BCD_ZERO   = 4'h0;
  localparam logic [3:0]  BCD_ONE    = 4'h1;
  localparam int          WORD_DIGITS  = 4;
  localparam int          DWORD_DIGITS = 8;

  // Storage word map
  localparam int               IDX_W      = 11;
  localparam logic [IDX_W-1:0] SLOT_STEP  = 11'h001;
  localparam logic [IDX_W-1:0] CTR_OFFSET = 11'h3E8;  // 1000
  localparam logic [IDX_W-1:0] AT_NUM     = 11'h000;
  localparam logic [IDX_W-1:0] FT_NUM     = AT_NUM + 11'h002;
  localparam logic [IDX_W-1:0] SI_NUM     = FT_NUM + 11'h002;
  localparam logic [IDX_W-1:0] UC_NUM     = 11'h000;
  localparam logic [IDX_W-1:0] UD_NUM     = 11'h001;
  localparam logic [IDX_W-1:0] SC_NUM     = UD_NUM + 11'h002;
  localparam logic [IDX_W-1:0] UC_WORD    = UC_NUM + CTR_OFFSET;
  localparam logic [IDX_W-1:0] UD_WORD    = UD_NUM + CTR_OFFSET;
  localparam logic [IDX_W-1:0] SC_WORD    = SC_NUM + CTR_OFFSET;

endpackage

// ===== hw/bcd_step.sv
// Packed BCD increment or decrement by one, any digit count.
// Combinational; the caller handles saturation at the range ends.
`timescale 1ns/1ps
`default_nettype none

module bcd_step
  import bcd_timer_pkg::*;
#(
  parameter int DIGITS = 4
)
(
  input  wire logic [4*DIGITS-1:0] val_in,   // Current value
  input  wire logic                down,     // High steps down
  output logic      [4*DIGITS-1:0] val_out   // Stepped value
);

  logic [DIGITS:0]   carry;
  logic [DIGITS-1:0] hit;

  assign carry[0] = 1'b1;

  // Carry or borrow ripples one decimal digit at a time
  for (genvar g = 0; g < DIGITS; g++)
  begin : dig
    logic [3:0] d;
    assign d          = val_in[4*g +: 4];
    assign hit[g]     = down ? (d == BCD_ZERO) : (d == BCD_NINE);
    assign carry[g+1] = carry[g] & hit[g];
    assign val_out[4*g +: 4] = !carry[g] ? d :
                               hit[g] ? (down ? BCD_NINE : BCD_ZERO) :
                               (down ? d - BCD_ONE : d + BCD_ONE);
  end

endmodule
`default_nettype wire

// ===== hw/bcd_timer_bank.sv
// Bank of BCD timers and counters driven by scan-level inputs.
// Inputs are synchronous to CLK_SYS; edges are seen between cycles.
`timescale 1ns/1ps
`default_nettype none

module bcd_timer_bank
  import bcd_timer_pkg::*;
#(
  parameter int unsigned FAST_DIV = FAST_TICK_CYCLES
)
(
  input  wire logic             CLK_SYS,     // System clock
  input  wire logic             RST_N,       // Sync reset
  input  wire logic             AT_EN,       // Accum timer enable
  input  wire logic             AT_RST,      // Accum timer reset
  input  wire logic [31:0]      AT_PRESET,   // Accum timer preset
  input  wire logic             FT_EN,       // Fast timer enable
  input  wire logic             FT_RST,      // Fast timer reset
  input  wire logic [31:0]      FT_PRESET,   // Fast timer preset
  input  wire logic             SI_IN,       // Single timer input
  input  wire logic [15:0]      SI_PRESET,   // Single timer preset
  input  wire logic             UC_IN,       // Up counter count
  input  wire logic             UC_RST,      // Up counter reset
  input  wire logic [15:0]      UC_PRESET,   // Up counter preset
  input  wire logic             UD_UP,       // Up/down count up
  input  wire logic             UD_DOWN,     // Up/down count down
  input  wire logic             UD_RST,      // Up/down reset
  input  wire logic [31:0]      UD_PRESET,   // Up/down preset
  input  wire logic             SC_IN,       // Stage counter count
  input  wire logic             SC_CLR_CMD,  // Stage reset command
  input  wire logic [15:0]      SC_PRESET,   // Stage preset
  input  wire logic [IDX_W-1:0] RD_INDEX,    // Storage word index
  output logic      [15:0]      RD_DATA,     // Storage word
  output logic                  AT_DONE,     // Accum timer done
  output logic                  FT_DONE,     // Fast timer done
  output logic                  SI_DONE,     // Single timer done
  output logic                  UC_DONE,     // Up counter status
  output logic                  UD_DONE,     // Up/down status
  output logic                  SC_DONE      // Stage status
);

  localparam logic [PRESC_W-1:0]  PRESC_LAST  = PRESC_W'(FAST_DIV - 1);
  localparam logic [DECADE_W-1:0] DECADE_LAST = DECADE_W'(FAST_PER_SLOW - 1);

  logic [PRESC_W-1:0]  presc_reg;
  logic [DECADE_W-1:0] decade_reg;
  logic                fast_tick_reg;
  logic                slow_tick_reg;

  logic [31:0] at_reg, at_next, at_inc;
  logic [31:0] ft_reg, ft_next, ft_inc;
  logic [15:0] si_reg, si_next, si_inc;
  logic [15:0] uc_reg, uc_next, uc_inc;
  logic [31:0] ud_reg, ud_next, ud_step;
  logic [15:0] sc_reg, sc_next, sc_inc;
  logic        uc_in_reg, ud_up_reg, ud_dn_reg, sc_in_reg;
  logic        uc_edge, ud_up_edge, ud_dn_edge, sc_edge;
  logic        at_done_reg, ft_done_reg, si_done_reg;
  logic        uc_done_reg, ud_done_reg, sc_done_reg;
  logic [15:0] rd_data_reg;

  // Timebase: fast tick every 0.01 s, slow tick every tenth fast tick
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      presc_reg     <= '0;
      fast_tick_reg <= 1'b0;
    end
    else
    begin
      presc_reg     <= (presc_reg == PRESC_LAST) ? '0 : presc_reg + 1'b1;
      fast_tick_reg <= (presc_reg == PRESC_LAST);
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      decade_reg    <= '0;
      slow_tick_reg <= 1'b0;
    end
    else
    begin
      slow_tick_reg <= (presc_reg == PRESC_LAST) && (decade_reg == DECADE_LAST);
      if (presc_reg == PRESC_LAST)
        decade_reg <= (decade_reg == DECADE_LAST) ? '0 : decade_reg + 1'b1;
    end
  end

  // Edge detection of count inputs
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      uc_in_reg <= 1'b0;
      ud_up_reg <= 1'b0;
      ud_dn_reg <= 1'b0;
      sc_in_reg <= 1'b0;
    end
    else
    begin
      uc_in_reg <= UC_IN;
      ud_up_reg <= UD_UP;
      ud_dn_reg <= UD_DOWN;
      sc_in_reg <= SC_IN;
    end
  end

  assign uc_edge    = UC_IN & ~uc_in_reg;
  assign ud_up_edge = UD_UP & ~ud_up_reg;
  assign ud_dn_edge = UD_DOWN & ~ud_dn_reg;
  assign sc_edge    = SC_IN & ~sc_in_reg;

  // Decimal steppers
  bcd_step #(.DIGITS(DWORD_DIGITS)) u_at_step
  (
    .val_in  (at_reg),
    .down    (1'b0),
    .val_out (at_inc)
  );

  bcd_step #(.DIGITS(DWORD_DIGITS)) u_ft_step
  (
    .val_in  (ft_reg),
    .down    (1'b0),
    .val_out (ft_inc)
  );

  bcd_step #(.DIGITS(WORD_DIGITS)) u_si_step
  (
    .val_in  (si_reg),
    .down    (1'b0),
    .val_out (si_inc)
  );

  bcd_step #(.DIGITS(WORD_DIGITS)) u_uc_step
  (
    .val_in  (uc_reg),
    .down    (1'b0),
    .val_out (uc_inc)
  );

  bcd_step #(.DIGITS(DWORD_DIGITS)) u_ud_step
  (
    .val_in  (ud_reg),
    .down    (ud_dn_edge),
    .val_out (ud_step)
  );

  bcd_step #(.DIGITS(WORD_DIGITS)) u_sc_step
  (
    .val_in  (sc_reg),
    .down    (1'b0),
    .val_out (sc_inc)
  );

  // Next values of the timers
  always_comb
  begin
    at_next = at_reg;
    if (AT_RST)
      at_next = DWORD_ZERO;
    else if (AT_EN && slow_tick_reg && at_reg != AT_MAX)
      at_next = at_inc;
    ft_next = ft_reg;
    if (FT_RST)
      ft_next = DWORD_ZERO;
    else if (FT_EN && fast_tick_reg && ft_reg != FT_MAX)
      ft_next = ft_inc;
    si_next = si_reg;
    if (!SI_IN)
      si_next = WORD_ZERO;
    else if (slow_tick_reg && si_reg != WORD_MAX)
      si_next = si_inc;
  end

  // Next values of the counters
  always_comb
  begin
    uc_next = uc_reg;
    if (UC_RST)
      uc_next = WORD_ZERO;
    else if (uc_edge && uc_reg != WORD_MAX)
      uc_next = uc_inc;
    ud_next = ud_reg;
    if (UD_RST)
      ud_next = DWORD_ZERO;
    else if (ud_up_edge && !UD_DOWN && ud_reg != UD_MAX)
      ud_next = ud_step;
    else if (ud_dn_edge && !UD_UP && ud_reg != DWORD_ZERO)
      ud_next = ud_step;
    sc_next = sc_reg;
    if (SC_CLR_CMD)
      sc_next = WORD_ZERO;
    else if (sc_edge && sc_reg != WORD_MAX)
      sc_next = sc_inc;
  end

  // Current value storage
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      at_reg <= DWORD_ZERO;
      ft_reg <= DWORD_ZERO;
      si_reg <= WORD_ZERO;
    end
    else
    begin
      at_reg <= at_next;
      ft_reg <= ft_next;
      si_reg <= si_next;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      uc_reg <= WORD_ZERO;
      ud_reg <= DWORD_ZERO;
      sc_reg <= WORD_ZERO;
    end
    else
    begin
      uc_reg <= uc_next;
      ud_reg <= ud_next;
      sc_reg <= sc_next;
    end
  end

  // Done and status bits: value at or above preset, off while cleared
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      at_done_reg <= 1'b0;
      ft_done_reg <= 1'b0;
      si_done_reg <= 1'b0;
      uc_done_reg <= 1'b0;
      ud_done_reg <= 1'b0;
      sc_done_reg <= 1'b0;
    end
    else
    begin
      at_done_reg <= !AT_RST && (at_next >= AT_PRESET);
      ft_done_reg <= !FT_RST && (ft_next >= FT_PRESET);
      si_done_reg <= SI_IN && (si_next >= SI_PRESET);
      uc_done_reg <= !UC_RST && (uc_next >= UC_PRESET);
      ud_done_reg <= !UD_RST && (ud_next >= UD_PRESET);
      sc_done_reg <= !SC_CLR_CMD && (sc_next >= SC_PRESET);
    end
  end

  // Storage word read port; double words keep the low half at the base
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
      rd_data_reg <= WORD_ZERO;
    else
    begin
      case (RD_INDEX)
        AT_NUM:             rd_data_reg <= at_reg[15:0];
        AT_NUM + SLOT_STEP: rd_data_reg <= at_reg[31:16];
        FT_NUM:             rd_data_reg <= ft_reg[15:0];
        FT_NUM + SLOT_STEP: rd_data_reg <= ft_reg[31:16];
        SI_NUM:             rd_data_reg <= si_reg;
        UC_WORD:            rd_data_reg <= uc_reg;
        UD_WORD:            rd_data_reg <= ud_reg[15:0];
        UD_WORD + SLOT_STEP: rd_data_reg <= ud_reg[31:16];
        SC_WORD:            rd_data_reg <= sc_reg;
        default:            rd_data_reg <= WORD_ZERO;
      endcase
    end
  end

  assign RD_DATA = rd_data_reg;
  assign AT_DONE = at_done_reg;
  assign FT_DONE = ft_done_reg;
  assign SI_DONE = si_done_reg;
  assign UC_DONE = uc_done_reg;
  assign UD_DONE = ud_done_reg;
  assign SC_DONE = sc_done_reg;

  // Checks
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  at_tick_step_a: assert property (
    slow_tick_reg && AT_EN && !AT_RST && at_reg != AT_MAX
    |=> at_reg != $past(at_reg))
    else $error("accum timer missed a tick");

  ft_range_a: assert property (
    ft_reg <= FT_MAX)
    else $error("fast timer beyond its range");

  at_freeze_a: assert property (
    !AT_EN && !AT_RST |=> at_reg == $past(at_reg))
    else $error("accum timer moved while disabled");

  at_reset_a: assert property (
    AT_RST |=> at_reg == DWORD_ZERO && !AT_DONE)
    else $error("accum timer not cleared by reset");

  at_done_a: assert property (
    $past(RST_N) && !$past(AT_RST)
    |-> AT_DONE == (at_reg >= $past(AT_PRESET)))
    else $error("accum timer done disagrees with value");

  si_clear_a: assert property (
    !SI_IN |=> si_reg == WORD_ZERO && !SI_DONE)
    else $error("single timer not cleared");

  uc_steady_a: assert property (
    !UC_RST && UC_IN == uc_in_reg |=> $stable(uc_reg))
    else $error("up counter moved without an edge");

  uc_reset_a: assert property (
    UC_RST |=> uc_reg == WORD_ZERO && !UC_DONE)
    else $error("up counter not cleared by reset");

  uc_sat_a: assert property (
    uc_reg == WORD_MAX && !UC_RST |=> uc_reg == WORD_MAX)
    else $error("up counter left saturation");

  ud_down_a: assert property (
    ud_dn_edge && !UD_UP && !UD_RST && ud_reg != DWORD_ZERO
    |=> ud_reg < $past(ud_reg))
    else $error("up/down counter missed a down edge");

  sc_hold_a: assert property (
    !SC_CLR_CMD && sc_reg != WORD_ZERO |=> sc_reg != WORD_ZERO)
    else $error("stage counter cleared without command");

  at_done_c: cover property (
    !AT_DONE ##1 AT_DONE);

  ud_down_c: cover property (
    ud_dn_edge && !UD_UP && !UD_RST && ud_reg != DWORD_ZERO);

  sc_sat_c: cover property (
    sc_reg == WORD_MAX && sc_edge);

endmodule
`default_nettype wire

// ===== tb/scan_ctrl.sv
// Controller model: bursts of count pulses plus held levels.
// Assumes the bank's clock and reset; one pulse is 1 high, 1 low.
`timescale 1ns/1ps
`default_nettype none

module scan_ctrl
(
  input  wire logic        clk,    // Clock
  input  wire logic        rst_n,  // Sync reset
  input  wire logic        go,     // Start burst
  input  wire logic [3:0]  sel,    // Lines to pulse
  input  wire logic [15:0] n,      // Pulse count
  input  wire logic [3:0]  lvl,    // Held levels
  output logic      [3:0]  lines,  // Count lines
  output logic             busy    // Burst running
);
  logic [15:0] rem_reg;
  logic        ph_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rem_reg <= 16'h0000;
      ph_reg  <= 1'b0;
    end
    else if (go)
    begin
      rem_reg <= n;
      ph_reg  <= 1'b0;
    end
    else if (rem_reg != 16'h0000)
    begin
      ph_reg <= ~ph_reg;
      if (ph_reg)
        rem_reg <= rem_reg - 16'h0001;
    end
  end

  // Lines idle at their held level, so a burst pulse is a real rise only where lvl is low
  assign lines = (sel & {4{ph_reg}}) | lvl;
  assign busy  = (rem_reg != 16'h0000);
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the BCD timer and counter bank.
// Assumes FAST_DIV of 4, so a slow tick is 40 cycles.
`timescale 1ns/1ps
`default_nettype none

module testbench
  import bcd_timer_pkg::*;
;
  typedef struct packed {logic [15:0] w; logic m; logic [2:0] s; logic d;} note_t;
  note_t            q[$];
  event             obs_ev;
  logic             clk    = 1'b0;
  logic             rst_n  = 1'b0;
  logic             at_en  = 1'b0;
  logic             at_rst = 1'b0;
  logic             ft_en  = 1'b0;
  logic             ft_rst = 1'b0;
  logic             si_in  = 1'b0;
  logic             uc_rst = 1'b0;
  logic             ud_rst = 1'b0;
  logic             sc_clr = 1'b0;
  logic             go     = 1'b0;
  logic [31:0]      ft_p   = 32'h0000_0012;
  logic [15:0]      uc_p   = 16'h0010;
  logic [15:0]      n      = 16'h0000;
  logic [3:0]       sel    = 4'h0;
  logic [3:0]       lvl    = 4'h0;
  logic [IDX_W-1:0] idx    = 11'h000;
  logic [31:0]      seed   = 32'h0000_02E9;
  logic [3:0]       lines;
  logic [15:0]      rd;
  logic [5:0]       dn;
  logic             busy;
  int               n_errors = 0;
  int               total_checks = 0;

  always #5 clk = ~clk;

  bcd_timer_bank #(.FAST_DIV(4)) u_dut (
    .CLK_SYS(clk), .RST_N(rst_n),
    .AT_EN(at_en), .AT_RST(at_rst), .AT_PRESET(32'h0000_0003),
    .FT_EN(ft_en), .FT_RST(ft_rst), .FT_PRESET(ft_p),
    .SI_IN(si_in), .SI_PRESET(16'h0003),
    .UC_IN(lines[0]), .UC_RST(uc_rst), .UC_PRESET(uc_p),
    .UD_UP(lines[1]), .UD_DOWN(lines[2]), .UD_RST(ud_rst), .UD_PRESET(32'h0000_0003),
    .SC_IN(lines[3]), .SC_CLR_CMD(sc_clr), .SC_PRESET(16'h0002),
    .RD_INDEX(idx), .RD_DATA(rd),
    .AT_DONE(dn[0]), .FT_DONE(dn[1]), .SI_DONE(dn[2]),
    .UC_DONE(dn[3]), .UD_DONE(dn[4]), .SC_DONE(dn[5])
  );

  scan_ctrl u_ctrl (
    .clk(clk), .rst_n(rst_n), .go(go), .sel(sel), .n(n),
    .lvl(lvl), .lines(lines), .busy(busy)
  );

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic [15:0] bcd4(input int v);
    return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction

  task automatic end_sim();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (e !== g)
    begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp1(input logic e, input logic g);
    cmp16({15'h0000, e}, {15'h0000, g});
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Word and done bit are sampled mid-cycle, after the one-cycle read latency
  task automatic chk(input logic [IDX_W-1:0] i, input logic [15:0] w, input logic [2:0] s, input logic d);
    idx <= i;
    cyc(1);
    @(negedge clk);
    q.push_back(note_t'{w, 1'b1, s, d});
    -> obs_ev;
    cyc(1);
  endtask

  // Done bit is sampled at the next falling edge, away from the launching edge
  task automatic dchk(input logic [2:0] s, input logic d);
    @(negedge clk);
    q.push_back(note_t'{16'h0000, 1'b0, s, d});
    -> obs_ev;
    cyc(1);
  endtask

  task automatic pulse(input logic [3:0] s, input int k);
    int i;
    sel <= s;
    n   <= 16'(k);
    go  <= 1'b1;
    cyc(1);
    go  <= 1'b0;
    cyc(1);
    for (i = 0; busy === 1'b1 && i < 2 * k + 8; i++)
      cyc(1);
    if (busy !== 1'b0)
    begin
      n_errors++;
      end_sim();
    end
  endtask

  always @(obs_ev)
  begin
    note_t e;
    e = q.pop_front();
    if (e.m)
      cmp16(e.w, rd);
    cmp1(e.d, dn[e.s]);
  end

  initial
  begin
    int k;
    int p;
    cyc(4);
    rst_n <= 1'b1;
    cyc(1);
    chk(11'h3E8, 16'h0000, 3'd3, 1'b0);
    chk(11'h005, 16'h0000, 3'd0, 1'b0);
    $display("test reset done");
    at_en <= 1'b1;
    cyc(120);
    at_en <= 1'b0;
    chk(11'h000, 16'h0003, 3'd0, 1'b1);
    cyc(80);
    chk(11'h000, 16'h0003, 3'd0, 1'b1);
    chk(11'h001, 16'h0000, 3'd0, 1'b1);
    at_rst <= 1'b1;
    at_en  <= 1'b1;
    cyc(80);
    chk(11'h000, 16'h0000, 3'd0, 1'b0);
    at_rst <= 1'b0;
    at_en  <= 1'b0;
    $display("test accum timer done");
    ft_en <= 1'b1;
    cyc(48);
    ft_en <= 1'b0;
    chk(11'h002, 16'h0012, 3'd1, 1'b1);
    ft_en <= 1'b1;
    cyc(44);
    ft_en <= 1'b0;
    ft_p  <= 32'h0000_0024;
    chk(11'h002, 16'h0023, 3'd1, 1'b0);
    chk(11'h003, 16'h0000, 3'd1, 1'b0);
    ft_rst <= 1'b1;
    cyc(1);
    chk(11'h002, 16'h0000, 3'd1, 1'b0);
    ft_rst <= 1'b0;
    $display("test fast timer done");
    si_in <= 1'b1;
    cyc(120);
    si_in <= 1'b0;
    dchk(3'd2, 1'b1);
    dchk(3'd2, 1'b0);
    chk(11'h004, 16'h0000, 3'd2, 1'b0);
    $display("test single timer done");
    seed = xs(seed);
    k = 1 + int'(seed % 40);
    seed = xs(seed);
    p = int'(seed % 40);
    uc_p <= bcd4(p);
    pulse(4'h1, k);
    chk(11'h3E8, bcd4(k), 3'd3, k >= p);
    lvl <= 4'h1;
    cyc(20);
    chk(11'h3E8, bcd4(k + 1), 3'd3, k + 1 >= p);
    lvl    <= 4'h0;
    uc_rst <= 1'b1;
    pulse(4'h1, 3);
    chk(11'h3E8, 16'h0000, 3'd3, 1'b0);
    uc_rst <= 1'b0;
    pulse(4'h1, 10001);
    chk(11'h3E8, 16'h9999, 3'd3, 1'b1);
    $display("test up counter done");
    pulse(4'h2, 5);
    chk(11'h3E9, 16'h0005, 3'd4, 1'b1);
    pulse(4'h4, 3);
    chk(11'h3E9, 16'h0002, 3'd4, 1'b0);
    lvl <= 4'h2;
    pulse(4'h4, 2);
    chk(11'h3E9, 16'h0003, 3'd4, 1'b1);
    lvl <= 4'h0;
    pulse(4'h4, 5);
    chk(11'h3E9, 16'h0000, 3'd4, 1'b0);
    chk(11'h3EA, 16'h0000, 3'd4, 1'b0);
    pulse(4'h2, 4);
    ud_rst <= 1'b1;
    pulse(4'h2, 2);
    chk(11'h3E9, 16'h0000, 3'd4, 1'b0);
    ud_rst <= 1'b0;
    $display("test up down counter done");
    pulse(4'h8, 3);
    chk(11'h3EB, 16'h0003, 3'd5, 1'b1);
    lvl <= 4'h8;
    cyc(20);
    chk(11'h3EB, 16'h0004, 3'd5, 1'b1);
    lvl    <= 4'h0;
    sc_clr <= 1'b1;
    cyc(1);
    chk(11'h3EB, 16'h0000, 3'd5, 1'b0);
    sc_clr <= 1'b0;
    $display("test stage counter done");
    cyc(2);
    end_sim();
  end
endmodule

`default_nettype wire
